/* File: erwc_consts.vh */
`ifndef ERWC_CONSTS_VH
`define ERWC_CONSTS_VH
// Bus width choices for the memory data path
`define ERWC_BUS16 1'b0
`define ERWC_BUS32 1'b1
// Quantum sizes in bytes
`define ERWC_Q16_BYTES 3'h2
`define ERWC_Q32_BYTES 3'h4
// Bus response codes
`define ERWC_RESP_OKAY 2'h0
`define ERWC_RESP_ERR 2'h2
// Number of protected ranges
`define ERWC_NRANGES 4
`endif

/* File: erwc_quantum_check.v */
`include "erwc_consts.vh"
module erwc_quantum_check #(
  parameter AW = 32,
  parameter LW = 12
) (
  // Access
  input  wire [AW-1:0] addr_i,
  input  wire [LW-1:0] len_i,
  input  wire          bus32_i,
  // Verdict
  output wire          legal_o
);
  wire [1:0] mask;
  // Alignment mask follows quantum size
  assign mask = (bus32_i == `ERWC_BUS32) ? 2'h3 : 2'h1;
  // Start and length both whole quanta
  assign legal_o = ((addr_i[1:0] & mask) == 2'h0) &&
                   ((len_i[1:0] & mask) == 2'h0) && (len_i != {LW{1'b0}});
endmodule

/* File: erwc_checker.v */
`include "erwc_consts.vh"
// Behaviour
// [R1] Inside ECC ranges only writes covering whole aligned quanta (16 or 32 bits) are legal.
// [R2] Initiators must write whole aligned quanta into ECC ranges.
// [R3] Every write is compared with the ECC ranges and a partial-quantum hit is detected; the code checks only each write's start address.
// [R4] A detected illegal write raises the error interrupt toward the CPU.
// [R5] A detected illegal write gets an error status on its bus response.
// [R6] Access type and initiator of the latest illegal write are logged, replacing older ones.
// [R7] The error interrupt is raised only for genuinely illegal writes to ECC space.
// [R8] Reads and legal writes always get a non-error response.
module erwc_checker #(
  parameter AW  = 32,
  parameter LW  = 12,
  parameter IDW = 6,
  parameter TW  = 4,
  parameter NR  = `ERWC_NRANGES
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             arst_n_i,
  input  wire             ce_i,
  // Configuration
  input  wire             bus32_i,
  input  wire [NR-1:0]    rng_en_i,
  input  wire [NR*AW-1:0] rng_lo_i,
  input  wire [NR*AW-1:0] rng_hi_i,
  // Request
  input  wire             req_valid_i,
  output wire             req_ready_o,
  input  wire             req_write_i,
  input  wire [AW-1:0]    req_addr_i,
  input  wire [LW-1:0]    req_len_i,
  input  wire [IDW-1:0]   req_id_i,
  input  wire [TW-1:0]    req_type_i,
  // Response
  output wire             rsp_valid_o,
  output wire [1:0]       rsp_code_o,
  output wire [IDW-1:0]   rsp_id_o,
  // Error reporting
  output wire             err_irq_o,
  input  wire             err_clr_i,
  output wire [IDW-1:0]   log_id_o,
  output wire [TW-1:0]    log_type_o,
  output wire             log_valid_o
);

  // Range decode
  wire [NR-1:0]  rng_lo_ok;
  wire [NR-1:0]  rng_hi_ok;
  wire [NR-1:0]  rng_hit;
  wire           in_ecc;

  // Request qualifiers
  wire           take;
  wire           take_wr;
  wire           legal;
  wire           bad;
  wire           clr_req;

  // Response state
  reg            rsp_valid_r;
  reg            rsp_valid_nxt;
  reg  [1:0]     rsp_code_r;
  reg  [1:0]     rsp_code_nxt;
  reg  [IDW-1:0] rsp_id_r;
  reg  [IDW-1:0] rsp_id_nxt;

  // Error state
  reg            err_irq_r;
  reg            err_irq_nxt;
  reg  [IDW-1:0] log_id_r;
  reg  [IDW-1:0] log_id_nxt;
  reg  [TW-1:0]  log_type_r;
  reg  [TW-1:0]  log_type_nxt;
  reg            log_valid_r;
  reg            log_valid_nxt;

  genvar         g;

  // No queue behind the port, so only the enable can stall it
  assign req_ready_o = ce_i;
  assign take        = req_valid_i & ce_i;
  assign take_wr     = take & req_write_i;
  assign clr_req     = err_clr_i & ce_i;

  // [R3] Range compare per range
  generate
    for (g = 0; g < NR; g = g + 1) begin : g_rng
      assign rng_lo_ok[g] = (req_addr_i >= rng_lo_i[g*AW +: AW]);
      assign rng_hi_ok[g] = (req_addr_i <= rng_hi_i[g*AW +: AW]);
      assign rng_hit[g]   = rng_en_i[g] & rng_lo_ok[g] & rng_hi_ok[g];
    end
  endgenerate

  // [R3] Start address decides membership
  assign in_ecc = |rng_hit;

  // [R1] Quantum legality
  erwc_quantum_check #(
    .AW (AW),
    .LW (LW)
  ) u_qchk (
    .addr_i  (req_addr_i),
    .len_i   (req_len_i),
    .bus32_i (bus32_i),
    .legal_o (legal)
  );

  // [R7] Only illegal ECC writes count
  assign bad = take_wr & in_ecc & ~legal;

  // Response valid pulses once per taken request
  always @* begin
    rsp_valid_nxt = rsp_valid_r;
    if (ce_i) begin
      rsp_valid_nxt = take;
    end
  end

  // Response identity follows the taken request
  always @* begin
    rsp_id_nxt = rsp_id_r;
    if (take) begin
      rsp_id_nxt = req_id_i;
    end
  end

  // [R5] [R8] Error only on illegal write
  always @* begin
    rsp_code_nxt = rsp_code_r;
    if (take) begin
      if (bad) begin
        rsp_code_nxt = `ERWC_RESP_ERR;
      end else begin
        rsp_code_nxt = `ERWC_RESP_OKAY;
      end
    end
  end

  // [R4] Set wins over clear, so no offender is lost
  always @* begin
    err_irq_nxt = err_irq_r;
    if (bad) begin
      err_irq_nxt = 1'h1;
    end else if (clr_req) begin
      err_irq_nxt = 1'h0;
    end
  end

  // [R6] Latest offender overwrites log
  always @* begin
    log_id_nxt    = log_id_r;
    log_type_nxt  = log_type_r;
    log_valid_nxt = log_valid_r;
    if (bad) begin
      log_id_nxt    = req_id_i;
      log_type_nxt  = req_type_i;
      log_valid_nxt = 1'h1;
    end
  end

  // Response registers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_valid_r <= 1'h0;
    end else if (ce_i) begin
      rsp_valid_r <= rsp_valid_nxt;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_code_r <= `ERWC_RESP_OKAY;
    end else if (ce_i) begin
      rsp_code_r <= rsp_code_nxt;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_id_r <= {IDW{1'h0}};
    end else if (ce_i) begin
      rsp_id_r <= rsp_id_nxt;
    end
  end

  // Interrupt register
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_irq_r <= 1'h0;
    end else if (ce_i) begin
      err_irq_r <= err_irq_nxt;
    end
  end

  // Offender log registers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      log_id_r <= {IDW{1'h0}};
    end else if (ce_i) begin
      log_id_r <= log_id_nxt;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      log_type_r <= {TW{1'h0}};
    end else if (ce_i) begin
      log_type_r <= log_type_nxt;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      log_valid_r <= 1'h0;
    end else if (ce_i) begin
      log_valid_r <= log_valid_nxt;
    end
  end

  // Data outputs straight from flip-flops
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_code_o  = rsp_code_r;
  assign rsp_id_o    = rsp_id_r;
  assign err_irq_o   = err_irq_r;
  assign log_id_o    = log_id_r;
  assign log_type_o  = log_type_r;
  assign log_valid_o = log_valid_r;
endmodule

/* File: erwc_chk_asserts.sv */
module erwc_chk_asserts (input wire clk_i, arst_n_i, ce_i, req_valid_i, req_write_i,
  err_clr_i, rsp_valid_o, err_irq_o, log_valid_o, input wire [1:0] rsp_code_o,
  input wire [5:0] req_id_i, rsp_id_o, log_id_o);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire rq = req_valid_i && ce_i;
  wire bad = rsp_valid_o && rsp_code_o == 2'h2;
  a_rsp_taken: assert property (rq |=> rsp_valid_o) else $error("no rsp");
  a_read_ok: assert property (rq && !req_write_i |=> rsp_code_o == 2'h0) else $error("rd");
  a_rsp_id: assert property (rq |=> rsp_id_o == $past(req_id_i)) else $error("id");
  a_bad_irq: assert property (bad |-> err_irq_o) else $error("irq");
  a_irq_cause: assert property ($rose(err_irq_o) |-> bad) else $error("irq");
  a_log_last: assert property (bad |-> log_valid_o && log_id_o == rsp_id_o) else $error("log");
  a_irq_clear: assert property (err_clr_i && ce_i |=> !err_irq_o || bad) else $error("clr");
  c_bad: cover property (bad);
  c_read: cover property (rq && !req_write_i);
  c_clear: cover property ($fell(err_irq_o));
endmodule
bind erwc_checker erwc_chk_asserts u_chk (.*);

/* File: erwc_init_model.sv */
module erwc_init_model (input wire clk_i, output logic req_valid_i, req_write_i,
  output logic [31:0] req_addr_i, output logic [11:0] req_len_i,
  output logic [5:0] req_id_i, output logic [3:0] req_type_i);
  timeunit 1ns; timeprecision 1ps;
  initial {req_valid_i, req_write_i, req_addr_i, req_len_i, req_id_i, req_type_i} = 0;
  task send(input bit w, input bit [31:0] a, input bit [11:0] l);
    @(negedge clk_i) {req_valid_i, req_write_i, req_addr_i, req_len_i} = {1'b1, w, a, l};
    {req_id_i, req_type_i} = 10'($urandom);
    @(negedge clk_i) req_valid_i = 0;
    req_addr_i = ~a;
  endtask
endmodule

/* File: erwc_checker_test.sv */
module erwc_checker_test;
  timeunit 1ns; timeprecision 1ps;
  logic clk_i = 0, arst_n_i = 0, bus32_i = 0, err_clr_i = 0, ce_i = 1;
  wire [3:0] rng_en_i = 4'h5;
  wire [127:0] rng_lo_i = {32'h0000_0000, 32'h0000_5000, 32'h0000_3000, 32'h0000_1000};
  wire [127:0] rng_hi_i = {32'h0000_0000, 32'h0000_5fff, 32'h0000_3fff, 32'h0000_1fff};
  wire req_valid_i, req_write_i, req_ready_o, rsp_valid_o, err_irq_o, log_valid_o;
  wire [31:0] req_addr_i; wire [11:0] req_len_i; wire [1:0] rsp_code_o;
  wire [5:0] req_id_i, rsp_id_o, log_id_o; wire [3:0] req_type_i, log_type_o;
  int failures, compares, cyc;
`define CHK(x, e) begin compares++; if ((x) !== (e)) begin failures++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
  erwc_init_model m (.*);
  erwc_checker dut (.*);
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 3000) begin failures++; conclude(); end
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic bit bad(bit w, bit [31:0] a, bit [11:0] l);
    int q = bus32_i ? 4 : 2;
    bit r0 = a >= 32'h0000_1000 && a <= 32'h0000_1fff;
    bit r2 = a >= 32'h0000_5000 && a <= 32'h0000_5fff;
    return w && (r0 || r2) && (a % q || l % q || !l);
  endfunction
  task go(bit w, bit [31:0] a, bit [11:0] l);
    bit e;
    e = bad(w, a, l);
    @(negedge clk_i) err_clr_i = 1;
    @(negedge clk_i) err_clr_i = 0;
    `CHK(err_irq_o, 1'b0)
    `CHK(req_ready_o, 1'b1)
    m.send(w, a, l);
    `CHK({rsp_valid_o, rsp_id_o}, {1'b1, req_id_i})
    `CHK(rsp_code_o, e ? 2'h2 : 2'h0)
    `CHK(err_irq_o, e)
    if (e) `CHK({log_valid_o, log_id_o, log_type_o}, {1'b1, req_id_i, req_type_i})
  endtask
  initial begin
    void'($urandom(57));
    repeat (5) @(negedge clk_i);
    arst_n_i = 1;
    for (int k = 0; k < 2; k++) begin
      bus32_i = k[0];
      go(1, 32'h0000_1002, 2);
      go(1, 32'h0000_1001, 4);
      go(1, 32'h0000_1000, 0);
      go(0, 32'h0000_1001, 1);
      go(1, 32'h0000_2001, 1);
      go(1, 32'h0000_1ffc, 4);
      go(1, 32'h0000_3001, 1);
      go(1, 32'h0000_5002, 4);
    end
    // Frozen by clock enable: request ignored
    go(0, 32'h0000_1000, 4);
    @(negedge clk_i) ce_i = 0;
    m.send(1, 32'h0000_1001, 1);
    `CHK({req_ready_o, rsp_valid_o, err_irq_o}, 3'b000)
    ce_i = 1;
    // Mid-run reset wipes sticky state
    go(1, 32'h0000_1001, 4);
    @(negedge clk_i) arst_n_i = 0;
    @(negedge clk_i) `CHK({rsp_valid_o, err_irq_o, log_valid_o}, 3'b000)
    arst_n_i = 1;
    repeat (300) begin
      bus32_i = 1'($urandom);
      go(1'($urandom), (($urandom % 2) ? 32'h0000_4ff8 : 32'h0000_0ff8) + $urandom % 4112,
         12'($urandom % 9));
    end
    conclude();
  end
endmodule
